//--- rtl/emc_pkg.sv
// Package for the Ethernet MIB statistics counter bank.
// Assumes one core clock and MAC event pulses on that clock.
package emc_pkg;

	localparam int NUM_CNT = 10;

	// Counter indices; the same index is the counter's mask bit
	localparam int IDX_MC_RX_OCT = 0;
	localparam int IDX_MC_RX_FRM = 1;
	localparam int IDX_PAUSE_RX = 2;
	localparam int IDX_OVERSIZE = 3;
	localparam int IDX_MC_TX_OCT = 4;
	localparam int IDX_MC_TX_FRM = 5;
	localparam int IDX_LATE_COL = 6;
	localparam int IDX_MULTI_COL = 7;
	localparam int IDX_CTRL_TX = 8;
	localparam int IDX_LEN_MISMATCH = 9;

	localparam logic [7:0] CNT_OFFSET [NUM_CNT] = '{8'hAC, 8'hB8, 8'hC6, 8'hC8, 8'hD4,
		8'hE0, 8'hE8, 8'hEC, 8'hFA, 8'hCA};
	localparam int CNT_WIDTH [NUM_CNT] = '{32, 32, 16, 16, 32, 32, 32, 32, 16, 16};

	localparam logic [31:0] CNT_RESET = 32'h0000_0000;
	localparam logic [31:0] THR16 = 32'h0000_C000;
	localparam logic [31:0] THR32 = 32'hC000_0000;
	localparam logic [31:0] MAX16 = 32'h0000_FFFF;
	localparam logic [31:0] MAX32 = 32'hFFFF_FFFF;

	localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
	localparam logic [15:0] VLAN_TAG_OCTETS = 16'h0004;
	localparam logic [15:0] MIN_UNPADDED_DEFAULT = 16'h002E;
	localparam logic [15:0] MAX_CLIENT_DEFAULT = 16'h05DC;
	localparam logic [15:0] SLOT_TIME_BITS_DEFAULT = 16'h0200;

	typedef struct packed {
		logic done;
		logic [15:0] frame_len;
		logic [15:0] len_type;
		logic [15:0] data_octets;
		logic dest_group;
		logic dest_bcast;
		logic fcs_err;
		logic align_err;
		logic overrun;
		logic mac_ctrl;
		logic [15:0] ctrl_opcode;
		logic tag_stripped;
	} emc_rx_evt_t;

	typedef struct packed {
		logic done;
		logic ok;
		logic dest_group;
		logic dest_bcast;
		logic [15:0] data_octets;
		logic tag_inserted;
		logic [4:0] coll_count;
		logic ctrl_self;
		logic collision;
		logic [15:0] elapsed_bits;
	} emc_tx_evt_t;

	typedef struct packed {
		logic [31:0] rdata;
		logic rvalid;
		logic evt;
	} emc_top_state_t;

endpackage

//--- rtl/emc_counter.sv
// One wrapping statistics counter with software load and threshold detect.
// Assumes the caller qualifies the increment with the enable and mask.
`timescale 1ns/1ps
`default_nettype none
module emc_counter #(
	parameter int W = 16,
	parameter logic [31:0] THRESH = emc_pkg::THR16
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic inc_in,
	input wire logic [W-1:0] inc_amt_in,
	input wire logic wr_in,
	input wire logic [W-1:0] wr_data_in,
	output logic [W-1:0] count_out,
	output logic hit_out
);
	typedef struct packed {
		logic [W-1:0] count;
		logic hit;
	} emc_cnt_state_t;

	emc_cnt_state_t state_r;
	emc_cnt_state_t state_nxt;
	logic [W-1:0] sum;

	always_comb begin
		state_nxt = state_r;
		state_nxt.hit = 1'b0;
		// Plain modular add: the all-ones value rolls to zero
		sum = state_r.count + inc_amt_in;
		// Software load wins over a same-cycle increment
		if (wr_in) begin
			state_nxt.count = wr_data_in;
		end else if (inc_in) begin
			state_nxt.count = sum;
			// Octet counters may step past the threshold, so detect the crossing
			state_nxt.hit = (state_r.count < THRESH[W-1:0]) && (sum >= THRESH[W-1:0]) && (sum >= state_r.count);
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			state_r <= '{count: emc_pkg::CNT_RESET[W-1:0], hit: 1'b0};
		end else begin
			state_r <= state_nxt;
		end
	end

	assign count_out = state_r.count;
	assign hit_out = state_r.hit;
endmodule
`default_nettype wire

//--- rtl/emc_stat_counters.sv
// Ethernet MIB statistics counter bank: event qualification, counters, register reads.
// Assumes MAC receive/transmit events arrive as one-cycle pulses on the core clock.
`timescale 1ns/1ps
`default_nettype none
module emc_stat_counters #(
	parameter logic [15:0] MIN_UNPADDED = emc_pkg::MIN_UNPADDED_DEFAULT,
	parameter logic [15:0] MAX_CLIENT = emc_pkg::MAX_CLIENT_DEFAULT,
	parameter logic [15:0] SLOT_TIME_BITS = emc_pkg::SLOT_TIME_BITS_DEFAULT
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire emc_pkg::emc_rx_evt_t rx_evt_in,
	input wire emc_pkg::emc_tx_evt_t tx_evt_in,
	input wire logic stats_global_enable_in,
	input wire logic [emc_pkg::NUM_CNT-1:0] stats_counter_mask_in,
	input wire logic [15:0] max_frame_length_setting_in,
	input wire logic stats_event_clear_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_rd_in,
	input wire logic reg_wr_in,
	input wire logic [31:0] reg_wdata_in,
	output logic [31:0] reg_rdata_out,
	output logic reg_rdata_valid_out,
	output logic stats_threshold_event_out
);
	emc_pkg::emc_top_state_t state_r;
	emc_pkg::emc_top_state_t state_nxt;

	logic oversize;
	logic len_inrange_err;
	logic len_short_err;
	logic rx_good;
	logic tx_good;
	logic [15:0] rx_octets;
	logic [15:0] tx_octets;
	logic [emc_pkg::NUM_CNT-1:0] cnt_raw;
	logic [emc_pkg::NUM_CNT-1:0] cnt_en;
	logic [emc_pkg::NUM_CNT-1:0] cnt_wr;
	logic [emc_pkg::NUM_CNT-1:0] cnt_hit;
	logic [31:0] cnt_amt [emc_pkg::NUM_CNT];
	logic [31:0] cnt_val [emc_pkg::NUM_CNT];

	assign oversize = rx_evt_in.frame_len > max_frame_length_setting_in;
	assign len_inrange_err = (rx_evt_in.len_type >= MIN_UNPADDED) && (rx_evt_in.len_type <= MAX_CLIENT)
		&& (rx_evt_in.len_type != rx_evt_in.data_octets);
	assign len_short_err = (rx_evt_in.len_type < MIN_UNPADDED) && (rx_evt_in.data_octets > MIN_UNPADDED);

	// good frame excludes every error kind
	assign rx_good = rx_evt_in.done && !oversize && !rx_evt_in.fcs_err && !rx_evt_in.align_err
		&& !len_inrange_err && !len_short_err && !rx_evt_in.overrun;
	assign tx_good = tx_evt_in.done && tx_evt_in.ok;

	// tag octets added back when stripped or inserted by hardware
	assign rx_octets = rx_evt_in.data_octets + (rx_evt_in.tag_stripped ? emc_pkg::VLAN_TAG_OCTETS : 16'h0000);
	assign tx_octets = tx_evt_in.data_octets + (tx_evt_in.tag_inserted ? emc_pkg::VLAN_TAG_OCTETS : 16'h0000);

	always_comb begin
		cnt_raw = '0;
		cnt_raw[emc_pkg::IDX_MC_RX_OCT] = rx_good && rx_evt_in.dest_group && !rx_evt_in.dest_bcast;
		cnt_raw[emc_pkg::IDX_MC_RX_FRM] = rx_good && rx_evt_in.dest_group && !rx_evt_in.dest_bcast;
		cnt_raw[emc_pkg::IDX_PAUSE_RX] = rx_good && rx_evt_in.mac_ctrl && (rx_evt_in.ctrl_opcode == emc_pkg::PAUSE_OPCODE);
		cnt_raw[emc_pkg::IDX_OVERSIZE] = rx_evt_in.done && oversize;
		cnt_raw[emc_pkg::IDX_MC_TX_OCT] = tx_good && tx_evt_in.dest_group && !tx_evt_in.dest_bcast;
		cnt_raw[emc_pkg::IDX_MC_TX_FRM] = tx_good && tx_evt_in.dest_group && !tx_evt_in.dest_bcast;
		cnt_raw[emc_pkg::IDX_LATE_COL] = tx_evt_in.collision && (tx_evt_in.elapsed_bits > SLOT_TIME_BITS);
		cnt_raw[emc_pkg::IDX_MULTI_COL] = tx_good && (tx_evt_in.coll_count > 5'h01);
		cnt_raw[emc_pkg::IDX_CTRL_TX] = tx_good && tx_evt_in.ctrl_self;
		cnt_raw[emc_pkg::IDX_LEN_MISMATCH] = rx_evt_in.done && (len_inrange_err || len_short_err);
	end

	assign cnt_en = cnt_raw & ~stats_counter_mask_in & {emc_pkg::NUM_CNT{stats_global_enable_in}};

	genvar gi;
	generate
		for (gi = 0; gi < emc_pkg::NUM_CNT; gi++) begin : g_cnt
			localparam int W = emc_pkg::CNT_WIDTH[gi];
			assign cnt_wr[gi] = reg_wr_in && (reg_addr_in == emc_pkg::CNT_OFFSET[gi]);
			if (gi == emc_pkg::IDX_MC_RX_OCT) begin : g_rxo
				assign cnt_amt[gi] = {16'h0000, rx_octets};
			end else if (gi == emc_pkg::IDX_MC_TX_OCT) begin : g_txo
				assign cnt_amt[gi] = {16'h0000, tx_octets};
			end else begin : g_one
				assign cnt_amt[gi] = 32'h0000_0001;
			end
			// wrap and threshold inside each counter
			emc_counter #(
				.W(W),
				.THRESH((W == 32) ? emc_pkg::THR32 : emc_pkg::THR16)
			) u_cnt (
				.clk_sys_in(clk_sys_in),
				.rst_n_in(rst_n_in),
				.inc_in(cnt_en[gi]),
				.inc_amt_in(cnt_amt[gi][W-1:0]),
				.wr_in(cnt_wr[gi]),
				.wr_data_in(reg_wdata_in[W-1:0]),
				.count_out(cnt_val[gi][W-1:0]),
				.hit_out(cnt_hit[gi])
			);
			if (W < 32) begin : g_pad
				assign cnt_val[gi][31:W] = '0;
			end
		end
	endgenerate

	always_comb begin
		state_nxt = state_r;
		state_nxt.rvalid = 1'b0;
		// sticky event; a new hit beats a same-cycle clear
		state_nxt.evt = (state_r.evt && !stats_event_clear_in) || (|cnt_hit);
		if (reg_rd_in) begin
			state_nxt.rvalid = 1'b1;
			// Unmapped offsets read as zero
			state_nxt.rdata = 32'h0000_0000;
			for (int i = 0; i < emc_pkg::NUM_CNT; i++) begin
				if (reg_addr_in == emc_pkg::CNT_OFFSET[i]) begin
					state_nxt.rdata = cnt_val[i];
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			state_r <= '{rdata: 32'h0000_0000, rvalid: 1'b0, evt: 1'b0};
		end else begin
			state_r <= state_nxt;
		end
	end

	assign reg_rdata_out = state_r.rdata;
	assign reg_rdata_valid_out = state_r.rvalid;
	assign stats_threshold_event_out = state_r.evt;

	// Checks
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);

	logic gate_on;
	assign gate_on = stats_global_enable_in;

	sequence s_hit16;
		cnt_en[emc_pkg::IDX_OVERSIZE] && !cnt_wr[emc_pkg::IDX_OVERSIZE]
			&& (cnt_val[emc_pkg::IDX_OVERSIZE] == emc_pkg::THR16 - 32'h1);
	endsequence

	sequence s_hit32;
		cnt_en[emc_pkg::IDX_LATE_COL] && !cnt_wr[emc_pkg::IDX_LATE_COL]
			&& (cnt_val[emc_pkg::IDX_LATE_COL] == emc_pkg::THR32 - 32'h1);
	endsequence

	sequence s_event_raised;
		##2 stats_threshold_event_out;
	endsequence

	AST_OVERSIZE_INC: assert property (
		rx_evt_in.done && (rx_evt_in.frame_len > max_frame_length_setting_in) && gate_on
			&& !stats_counter_mask_in[emc_pkg::IDX_OVERSIZE] && !cnt_wr[emc_pkg::IDX_OVERSIZE]
		|=> cnt_val[emc_pkg::IDX_OVERSIZE] == (($past(cnt_val[emc_pkg::IDX_OVERSIZE]) + 32'h1) & emc_pkg::MAX16)
	) else $error("oversize counter did not step");

	AST_WRAP16: assert property (
		cnt_en[emc_pkg::IDX_OVERSIZE] && !cnt_wr[emc_pkg::IDX_OVERSIZE]
			&& (cnt_val[emc_pkg::IDX_OVERSIZE] == emc_pkg::MAX16)
		|=> cnt_val[emc_pkg::IDX_OVERSIZE] == emc_pkg::CNT_RESET
	) else $error("16-bit counter did not wrap");

	AST_EVT16: assert property (
		s_hit16 |-> s_event_raised
	) else $error("16-bit threshold did not raise event");

	AST_LEN_INRANGE: assert property (
		rx_evt_in.done && gate_on && !stats_counter_mask_in[emc_pkg::IDX_LEN_MISMATCH]
			&& !cnt_wr[emc_pkg::IDX_LEN_MISMATCH] && (rx_evt_in.len_type >= MIN_UNPADDED)
			&& (rx_evt_in.len_type <= MAX_CLIENT) && (rx_evt_in.len_type != rx_evt_in.data_octets)
		|=> cnt_val[emc_pkg::IDX_LEN_MISMATCH] == (($past(cnt_val[emc_pkg::IDX_LEN_MISMATCH]) + 32'h1) & emc_pkg::MAX16)
	) else $error("in-range length error not counted");

	AST_LEN_SHORT: assert property (
		rx_evt_in.done && gate_on && !stats_counter_mask_in[emc_pkg::IDX_LEN_MISMATCH]
			&& !cnt_wr[emc_pkg::IDX_LEN_MISMATCH] && (rx_evt_in.len_type < MIN_UNPADDED)
			&& (rx_evt_in.data_octets > MIN_UNPADDED)
		|=> cnt_val[emc_pkg::IDX_LEN_MISMATCH] == (($past(cnt_val[emc_pkg::IDX_LEN_MISMATCH]) + 32'h1) & emc_pkg::MAX16)
	) else $error("short length error not counted");

	AST_LATE_COL: assert property (
		tx_evt_in.collision && (tx_evt_in.elapsed_bits <= SLOT_TIME_BITS) && !cnt_wr[emc_pkg::IDX_LATE_COL]
		|=> $stable(cnt_val[emc_pkg::IDX_LATE_COL])
	) else $error("early collision counted as late");

	AST_WRAP32: assert property (
		cnt_en[emc_pkg::IDX_LATE_COL] && !cnt_wr[emc_pkg::IDX_LATE_COL]
			&& (cnt_val[emc_pkg::IDX_LATE_COL] == emc_pkg::MAX32)
		|=> cnt_val[emc_pkg::IDX_LATE_COL] == emc_pkg::CNT_RESET
	) else $error("32-bit counter did not wrap");

	AST_EVT32: assert property (
		s_hit32 |-> s_event_raised
	) else $error("32-bit threshold did not raise event");

	AST_PAUSE_ONLY: assert property (
		rx_evt_in.done && rx_evt_in.mac_ctrl && (rx_evt_in.ctrl_opcode != emc_pkg::PAUSE_OPCODE)
			&& !cnt_wr[emc_pkg::IDX_PAUSE_RX]
		|=> $stable(cnt_val[emc_pkg::IDX_PAUSE_RX])
	) else $error("non-pause control frame counted");

	AST_CTRL_HOST: assert property (
		tx_evt_in.done && !tx_evt_in.ctrl_self && !cnt_wr[emc_pkg::IDX_CTRL_TX]
		|=> $stable(cnt_val[emc_pkg::IDX_CTRL_TX])
	) else $error("host control frame counted");

	AST_MC_RX_BAD: assert property (
		rx_evt_in.done && (rx_evt_in.dest_bcast || rx_evt_in.fcs_err || rx_evt_in.overrun)
			&& !cnt_wr[emc_pkg::IDX_MC_RX_FRM]
		|=> $stable(cnt_val[emc_pkg::IDX_MC_RX_FRM])
	) else $error("bad or broadcast frame counted as multicast");

	AST_MC_TX: assert property (
		tx_good && tx_evt_in.dest_group && !tx_evt_in.dest_bcast && gate_on
			&& !stats_counter_mask_in[emc_pkg::IDX_MC_TX_FRM] && !cnt_wr[emc_pkg::IDX_MC_TX_FRM]
		|=> cnt_val[emc_pkg::IDX_MC_TX_FRM] == $past(cnt_val[emc_pkg::IDX_MC_TX_FRM]) + 32'h1
	) else $error("multicast transmit not counted");

	AST_MC_RX_OCT: assert property (
		cnt_en[emc_pkg::IDX_MC_RX_OCT] && !cnt_wr[emc_pkg::IDX_MC_RX_OCT]
		|=> cnt_val[emc_pkg::IDX_MC_RX_OCT] == $past(cnt_val[emc_pkg::IDX_MC_RX_OCT]) + $past(cnt_amt[0])
	) else $error("receive octets not added");

	AST_MC_TX_OCT: assert property (
		cnt_en[emc_pkg::IDX_MC_TX_OCT] && !cnt_wr[emc_pkg::IDX_MC_TX_OCT]
		|=> cnt_val[emc_pkg::IDX_MC_TX_OCT] == $past(cnt_val[emc_pkg::IDX_MC_TX_OCT]) + $past(cnt_amt[4])
	) else $error("transmit octets not added");

	AST_VLAN_TAG: assert property (
		tx_evt_in.tag_inserted |-> tx_octets == tx_evt_in.data_octets + emc_pkg::VLAN_TAG_OCTETS
	) else $error("tag octets missing from total");

	AST_MULTI_COL: assert property (
		tx_good && (tx_evt_in.coll_count <= 5'h01) && !cnt_wr[emc_pkg::IDX_MULTI_COL]
		|=> $stable(cnt_val[emc_pkg::IDX_MULTI_COL])
	) else $error("single-collision frame counted as multiple");

	AST_GATED: assert property (
		(!stats_global_enable_in || stats_counter_mask_in[emc_pkg::IDX_MC_RX_FRM])
			&& !cnt_wr[emc_pkg::IDX_MC_RX_FRM]
		|=> $stable(cnt_val[emc_pkg::IDX_MC_RX_FRM])
	) else $error("disabled counter moved");

	AST_EVT_HOLD: assert property (
		stats_threshold_event_out && !stats_event_clear_in |=> stats_threshold_event_out
	) else $error("pending event dropped without service");

	AST_EVT_CAUSE: assert property (
		!stats_threshold_event_out && !$past(|cnt_hit) ##1 1'b1 |-> !stats_threshold_event_out || $past(|cnt_hit)
	) else $error("event raised without a threshold hit");
endmodule
`default_nettype wire

//--- testbench/emc_stat_counters_tb.sv
// Self-checking bench for the statistics counter bank, with a queue-free integer model.
// Assumes the bench drives every port directly; no partner model, default parameters.
`timescale 1ns/1ps
`default_nettype none
module emc_stat_counters_tb;
	logic clk_sys_in = 1'b0;
	logic rst_n_in = 1'b0;
	emc_pkg::emc_rx_evt_t rx_evt = '0;
	emc_pkg::emc_tx_evt_t tx_evt = '0;
	logic en = 1'b0;
	logic [emc_pkg::NUM_CNT-1:0] mask = '0;
	logic [15:0] max_len = 16'h05EE;
	logic ev_clr = 1'b0;
	logic [7:0] addr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic rvalid;
	logic ev;
	int fail_count = 0;
	int total_checks = 0;
	longint model [emc_pkg::NUM_CNT];
	logic model_ev = 1'b0;

	always #20 clk_sys_in = ~clk_sys_in;

	emc_stat_counters u_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .rx_evt_in(rx_evt), .tx_evt_in(tx_evt),
		.stats_global_enable_in(en), .stats_counter_mask_in(mask), .max_frame_length_setting_in(max_len),
		.stats_event_clear_in(ev_clr), .reg_addr_in(addr), .reg_rd_in(rd), .reg_wr_in(wr), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .reg_rdata_valid_out(rvalid), .stats_threshold_event_out(ev));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %08h expected %08h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] wmask(input int i);
		return (emc_pkg::CNT_WIDTH[i] == 16) ? emc_pkg::MAX16 : emc_pkg::MAX32;
	endfunction

	// Threshold is raised only on the step that crosses it, never by a wrap
	function automatic void bump(input int i, input longint amt);
		longint nv;
		logic [31:0] thr;
		if (!en || mask[i]) return;
		thr = (emc_pkg::CNT_WIDTH[i] == 16) ? emc_pkg::THR16 : emc_pkg::THR32;
		nv = model[i] + amt;
		if (model[i] < thr && nv >= thr && nv <= wmask(i)) model_ev = 1'b1;
		model[i] = nv & wmask(i);
	endfunction

	function automatic emc_pkg::emc_rx_evt_t mk_rx(input logic [15:0] fl, lt, d, input logic g, b, f, c,
			input logic [15:0] op, input logic tg);
		return '{1'b1, fl, lt, d, g, b, f, 1'b0, 1'b0, c, op, tg};
	endfunction

	function automatic emc_pkg::emc_tx_evt_t mk_tx(input logic dn, ok, g, b, input logic [15:0] d, input logic tg,
			input logic [4:0] cc, input logic s, col, input logic [15:0] el);
		return '{dn, ok, g, b, d, tg, cc, s, col, el};
	endfunction

	// Errored or oversize frames keep a matching length field so each counter sees one cause
	function automatic emc_pkg::emc_rx_evt_t rnd_rx();
		emc_pkg::emc_rx_evt_t r;
		r = mk_rx(16'($urandom_range(32'h5FA, 32'h3C)), 16'($urandom_range(32'h640)),
			16'($urandom_range(32'h5E0, 32'h14)), 1'($urandom), 1'($urandom), 1'($urandom_range(7) == 0),
			1'($urandom), 16'($urandom_range(2)), 1'($urandom));
		r.done = 1'($urandom);
		r.align_err = ($urandom_range(7) == 0);
		r.overrun = ($urandom_range(7) == 0);
		if (r.mac_ctrl) r.dest_group = 1'b0;
		if ($urandom_range(1) == 0) r.len_type = r.data_octets;
		if (r.fcs_err || r.align_err || r.overrun || r.frame_len > max_len) r.len_type = r.data_octets;
		return r;
	endfunction

	function automatic emc_pkg::emc_tx_evt_t rnd_tx();
		emc_pkg::emc_tx_evt_t t;
		t = mk_tx(1'($urandom), 1'($urandom_range(3) != 0), 1'($urandom), 1'($urandom),
			16'($urandom_range(32'h5E0, 32'h14)), 1'($urandom), 5'($urandom_range(3)), 1'($urandom),
			1'($urandom), 16'($urandom_range(32'h258, 32'h190)));
		if (t.ctrl_self) t.dest_group = 1'b0;
		return t;
	endfunction

	task automatic send(input emc_pkg::emc_rx_evt_t r, input emc_pkg::emc_tx_evt_t t);
		logic lenerr;
		logic good;
		@(posedge clk_sys_in);
		rx_evt <= r;
		tx_evt <= t;
		@(posedge clk_sys_in);
		rx_evt <= '0;
		tx_evt <= '0;
		lenerr = (r.len_type >= 16'h002E && r.len_type <= 16'h05DC && r.len_type != r.data_octets)
			|| (r.len_type < 16'h002E && r.data_octets > 16'h002E);
		good = r.done && !r.fcs_err && !r.align_err && !r.overrun && !lenerr && r.frame_len <= max_len;
		if (r.done && r.frame_len > max_len) bump(emc_pkg::IDX_OVERSIZE, 1);
		if (r.done && lenerr) bump(emc_pkg::IDX_LEN_MISMATCH, 1);
		if (good && r.dest_group && !r.dest_bcast) bump(emc_pkg::IDX_MC_RX_FRM, 1);
		if (good && r.dest_group && !r.dest_bcast) bump(emc_pkg::IDX_MC_RX_OCT, r.data_octets + (r.tag_stripped ? 4 : 0));
		if (good && r.mac_ctrl && r.ctrl_opcode == 16'h0001) bump(emc_pkg::IDX_PAUSE_RX, 1);
		if (t.done && t.ok && t.dest_group && !t.dest_bcast) bump(emc_pkg::IDX_MC_TX_FRM, 1);
		if (t.done && t.ok && t.dest_group && !t.dest_bcast) bump(emc_pkg::IDX_MC_TX_OCT, t.data_octets + (t.tag_inserted ? 4 : 0));
		if (t.done && t.ok && t.coll_count > 5'h01) bump(emc_pkg::IDX_MULTI_COL, 1);
		if (t.done && t.ok && t.ctrl_self) bump(emc_pkg::IDX_CTRL_TX, 1);
		if (t.collision && t.elapsed_bits > 16'h0200) bump(emc_pkg::IDX_LATE_COL, 1);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_in);
		rd <= 1'b0;
		#1;
		chk({31'h0, rvalid}, 32'h1);
		chk(rdata, exp);
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys_in);
		wr <= 1'b0;
		for (int i = 0; i < emc_pkg::NUM_CNT; i++) if (emc_pkg::CNT_OFFSET[i] == a) model[i] = d & wmask(i);
	endtask

	task automatic set_ctl(input logic e, input logic [emc_pkg::NUM_CNT-1:0] m, input logic [15:0] ml);
		@(posedge clk_sys_in);
		en <= e;
		mask <= m;
		max_len <= ml;
		#1;
	endtask

	task automatic clr_ev();
		@(posedge clk_sys_in);
		ev_clr <= 1'b1;
		@(posedge clk_sys_in);
		ev_clr <= 1'b0;
		model_ev = 1'b0;
	endtask

	task automatic end_test(input string name);
		for (int i = 0; i < emc_pkg::NUM_CNT; i++) rd_chk(emc_pkg::CNT_OFFSET[i], 32'(model[i]));
		repeat (2) @(posedge clk_sys_in);
		#1;
		chk({31'h0, ev}, {31'h0, model_ev});
		$display("test %s done", name);
	endtask

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	initial begin
		#(40 * 20000);
		fail_count++;
		give_verdict();
	end

	initial begin
		void'($urandom(32'hA7B3));
		for (int i = 0; i < emc_pkg::NUM_CNT; i++) model[i] = 0;
		repeat (8) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		end_test("reset");
		rd_chk(8'h00, 32'h0);
		set_ctl(1'b1, '0, 16'h05EE);
		send(mk_rx(16'h05EF, 16'h0064, 16'h0064, 0, 0, 0, 0, 16'h0, 0), '0);
		send(mk_rx(16'h05EE, 16'h0064, 16'h0064, 0, 0, 0, 0, 16'h0, 0), '0);
		send(mk_rx(16'h00C8, 16'h002E, 16'h0032, 0, 0, 0, 0, 16'h0, 0), '0);
		send(mk_rx(16'h00C8, 16'h05DC, 16'h05DB, 0, 0, 0, 0, 16'h0, 0), '0);
		send(mk_rx(16'h00C8, 16'h0028, 16'h002F, 0, 0, 0, 0, 16'h0, 0), '0);
		send(mk_rx(16'h00C8, 16'h0028, 16'h002E, 0, 0, 0, 0, 16'h0, 0), '0);
		send(mk_rx(16'h00C8, 16'h003C, 16'h003C, 1, 0, 0, 0, 16'h0, 1), '0);
		send(mk_rx(16'h00C8, 16'h003C, 16'h003C, 1, 1, 0, 0, 16'h0, 0), '0);
		send(mk_rx(16'h00C8, 16'h003C, 16'h003C, 1, 0, 1, 0, 16'h0, 0), '0);
		send(mk_rx(16'h00C8, 16'h003C, 16'h003C, 0, 0, 0, 1, 16'h0001, 0), '0);
		send(mk_rx(16'h00C8, 16'h003C, 16'h003C, 0, 0, 0, 1, 16'h0002, 0), '0);
		end_test("receive");
		send('0, mk_tx(0, 0, 0, 0, 16'h0, 0, 5'h0, 0, 1, 16'h0200));
		send('0, mk_tx(0, 0, 0, 0, 16'h0, 0, 5'h0, 0, 1, 16'h0201));
		send('0, mk_tx(1, 1, 1, 0, 16'h0064, 1, 5'h0, 0, 0, 16'h0));
		send('0, mk_tx(1, 1, 1, 1, 16'h0064, 0, 5'h0, 0, 0, 16'h0));
		send('0, mk_tx(1, 0, 1, 0, 16'h0064, 0, 5'h2, 0, 0, 16'h0));
		send('0, mk_tx(1, 1, 0, 0, 16'h0040, 0, 5'h1, 0, 0, 16'h0));
		send('0, mk_tx(1, 1, 0, 0, 16'h0040, 0, 5'h2, 1, 0, 16'h0));
		end_test("transmit");
		set_ctl(1'b0, '0, 16'h05EE);
		repeat (10) send(rnd_rx(), rnd_tx());
		end_test("disabled");
		for (int i = 0; i < emc_pkg::NUM_CNT; i++) begin
			set_ctl(1'b1, 10'(1 << i), 16'h05EE);
			repeat (8) send(rnd_rx(), rnd_tx());
		end
		end_test("mask");
		set_ctl(1'b1, '0, 16'h05EE);
		wr_reg(8'hC8, 32'h1234_BFFF);
		send(mk_rx(16'h05EF, 16'h0064, 16'h0064, 0, 0, 0, 0, 16'h0, 0), '0);
		end_test("threshold16");
		clr_ev();
		send(mk_rx(16'h05EF, 16'h0064, 16'h0064, 0, 0, 0, 0, 16'h0, 0), '0);
		wr_reg(8'hC8, 32'h0000_FFFF);
		send(mk_rx(16'h05EF, 16'h0064, 16'h0064, 0, 0, 0, 0, 16'h0, 0), '0);
		end_test("wrap16");
		wr_reg(8'hE8, 32'hBFFF_FFFF);
		send('0, mk_tx(0, 0, 0, 0, 16'h0, 0, 5'h0, 0, 1, 16'h0300));
		end_test("threshold32");
		clr_ev();
		wr_reg(8'hE8, 32'hFFFF_FFFF);
		send('0, mk_tx(0, 0, 0, 0, 16'h0, 0, 5'h0, 0, 1, 16'h0300));
		wr_reg(8'hAC, 32'hBFFF_FFF0);
		send(mk_rx(16'h00C8, 16'h0064, 16'h0064, 1, 0, 0, 0, 16'h0, 0), '0);
		wr_reg(8'h00, 32'h5555_5555);
		rd_chk(8'h00, 32'h0);
		end_test("wrap32");
		clr_ev();
		for (int k = 0; k < 12; k++) begin
			set_ctl(1'($urandom_range(3) != 0), 10'($urandom) & 10'($urandom), 16'($urandom_range(32'h600, 32'h500)));
			repeat (25) send(rnd_rx(), rnd_tx());
			end_test("random");
		end
		give_verdict();
	end
endmodule
`default_nettype wire
